// >>> rtl/bbc_top.sv
// Mode sequencing, setpoint registers and protection timing of the buck-boost controller
`timescale 1ns/1ps
module bbc_top
  import bbc_pkg::*;
#(
  parameter int LONG_US     = 1300000,
  parameter int SHORT_US    = 150000,
  parameter int WOC_SPAN_US = 50000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic [11:0] strapMv,
  input  wire bbc_conv_t   convMode,
  input  wire logic        deMode,
  input  wire logic        lowSideReq,
  input  wire logic        forwardEnablePin,
  input  wire logic        reverseEnablePin,
  input  wire logic        biasFromAdapter,
  input  wire logic        adapterAbove4v1,
  input  wire logic        systemAbove4v1,
  input  wire logic        adapterOvHigh,
  input  wire logic        adapterOvLow,
  input  wire logic        systemOvHigh,
  input  wire logic        systemOvLow,
  input  wire logic        fwdInRange,
  input  wire logic        rvsInRange,
  input  wire logic        adapterBelowRvsOv,
  input  wire logic        bypassWindow,
  input  wire logic        wocTrip,
  output logic [15:0]      regRdData,
  output logic             regRdValid,
  output logic             switchEnable,
  output logic             forwardPowerGood,
  output logic             reversePowerGood,
  output logic             strapCurrentOn,
  output logic             refCurrentOn,
  output logic             refFastPath,
  output logic             refToInput,
  output logic             passSwitchesOn,
  output bbc_de_t          deCompSel,
  output logic [2:0]       freqSel,
  output logic             lowSideGate,
  output logic             periodHold,
  output logic [11:0]      setpointCode,
  output logic             adapterOvFlag,
  output logic             systemOvFlag,
  output logic             wocShutdown
);
  // ==========================================================
  // Elaboration checks
  if (LONG_US >= 2 ** TMR_W || SHORT_US >= 2 ** TMR_W || WOC_SPAN_US >= 2 ** TMR_W) begin : g_chk_w
    $error("bbc_top: delay does not fit timer width");
  end
  if (SHORT_US < 1 || WOC_SPAN_US < 1 || MIN_LS_CYC >= 2 ** LS_W) begin : g_chk_v
    $error("bbc_top: delay out of range");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [N_PIN-1:0]   sync1;
    logic [N_PIN-1:0]   sync2;
    logic [TICK_W-1:0]  tickCnt;
    logic               tick;
    bbc_seq_t           seq;
    logic [STRAP_W-1:0] strapCnt;
    logic [11:0]        strapDef;
    logic [15:0]        ctl1;
    logic [15:0]        ctl2;
    logic [15:0]        fwdSp;
    logic [15:0]        rvsSp;
    logic               rvsPinEn;
    logic               rvsArmed;
    logic               adpOv;
    logic               sysOv;
    logic               bypLatched;
    logic [3:0]         wocWin;
    logic               wocUsed;
    logic [2:0]         wocTrips;
    logic [TMR_W-1:0]   wocSpan;
    logic               wocShut;
    logic [LS_W-1:0]    lsCnt;
    logic               lsPrev;
    logic [15:0]        rdData;
    logic               rdValid;
    logic               swEn;
    logic               fwdPg;
    logic               reverse_power_good;
    logic               strapSrc;
    logic               refCur;
    logic               refFast;
    logic               refIn;
    logic               passOn;
    bbc_de_t            deSel;
    logic [2:0]         freq;
    logic               lsGate;
    logic               hold;
    logic [11:0]        dac;
  } bbc_state_t;

  bbc_state_t r;
  bbc_state_t next_r;

  logic [N_PIN-1:0] pinVec;
  logic [N_PIN-1:0] p;
  logic             fwdAllowed;
  logic             rvsAllowed;
  logic             running;
  logic [N_TMR-1:0] tmrCond;
  logic [N_TMR-1:0] tmrDone;
  logic [TMR_W-1:0] tmrLim [N_TMR];

  assign pinVec = {wocTrip, bypassWindow, adapterBelowRvsOv, rvsInRange, fwdInRange, systemOvLow, systemOvHigh,
                   adapterOvLow, adapterOvHigh, systemAbove4v1, adapterAbove4v1, biasFromAdapter,
                   reverseEnablePin, forwardEnablePin};
  assign p = r.sync2;

  // ==========================================================
  // Debounce timers
  for (genvar i = 0; i < N_TMR; i++) begin : g_tmr
    bbc_tmr_if ti ();
    assign ti.tick  = r.tick;
    assign ti.cond  = tmrCond[i];
    assign ti.limit = tmrLim[i];
    assign tmrDone[i] = ti.done;
    bbc_debounce u_deb (
      .clk   (clk),
      .rst_n (rst_n),
      .t     (ti.tmr)
    );
  end

  always_comb begin
    fwdAllowed = (r.ctl2[C2_FWDEN] | p[PIN_FWD_EN]) & p[PIN_BIAS] & p[PIN_ADP_OK];
    rvsAllowed = (r.ctl1[C1_RVS] | r.rvsPinEn) & p[PIN_SYS_OK];
    running    = (r.seq == SEQ_FWD) || (r.seq == SEQ_RVS);
    tmrCond[T_RVSPIN] = p[PIN_RVS_EN];
    tmrLim[T_RVSPIN]  = r.ctl2[C2_RVSLONG] ? TMR_W'(LONG_US) : TMR_W'(SHORT_US);
    tmrCond[T_AOVSET] = p[PIN_AOV_HI] & ~r.adpOv;
    tmrLim[T_AOVSET]  = TMR_W'(ADP_OV_SET_US);
    tmrCond[T_AOVCLR] = p[PIN_AOV_LO] & r.adpOv;
    tmrLim[T_AOVCLR]  = TMR_W'(ADP_OV_CLR_US);
    tmrCond[T_SOVSET] = p[PIN_SOV_HI] & ~r.sysOv & ~r.bypLatched;
    tmrLim[T_SOVSET]  = TMR_W'(SYS_OV_SET_US);
    tmrCond[T_SOVCLR] = p[PIN_SOV_LO] & r.sysOv;
    tmrLim[T_SOVCLR]  = TMR_W'(SYS_OV_CLR_US);
    tmrCond[T_RETRY]  = r.wocShut;
    tmrLim[T_RETRY]   = r.ctl2[C2_WOCLONG] ? TMR_W'(LONG_US) : TMR_W'(SHORT_US);
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_r = r;
    next_r.sync1 = pinVec;
    next_r.sync2 = r.sync1;

    // One microsecond tick from a free-running count of clk
    if (r.tickCnt == TICK_W'(TICK_CYC - 1)) begin
      next_r.tickCnt = '0;
      next_r.tick    = 1'b1;
    end else begin
      next_r.tickCnt = r.tickCnt + 1'b1;
      next_r.tick    = 1'b0;
    end

    // Register writes and reads
    if (regWr) begin
      unique case (regAddr)
        ADDR_CTL1: next_r.ctl1 = regWrData;
        ADDR_CTL2: next_r.ctl2 = regWrData;
        ADDR_FWD_SP: next_r.fwdSp = regWrData;
        ADDR_RVS_SP: begin
          next_r.rvsSp = regWrData;
          if (regWrData[SP_MSB:SP_LSB] > SP_MAX) begin
            next_r.rvsSp[SP_MSB:SP_LSB] = SP_MAX;
          end
        end
        default: ;
      endcase
    end
    next_r.rdValid = regRd;
    if (regRd) begin
      unique case (regAddr)
        ADDR_CTL1: next_r.rdData = r.ctl1;
        ADDR_CTL2: next_r.rdData = r.ctl2;
        ADDR_FWD_SP: next_r.rdData = r.fwdSp;
        ADDR_RVS_SP: next_r.rdData = r.rvsSp;
        ADDR_STATUS: next_r.rdData = {5'h00, r.seq, r.wocTrips, r.wocShut, r.bypLatched,
                                      r.sysOv, r.adpOv, r.rvsArmed};
        default: next_r.rdData = 16'h0000;
      endcase
    end

    // Reverse pin: fast-swap bit skips the debounce, whether long or short
    next_r.rvsPinEn = p[PIN_RVS_EN] & (r.ctl2[C2_RVSFAST] | tmrDone[T_RVSPIN]);

    // Overvoltage flags
    if (!r.adpOv && tmrDone[T_AOVSET]) begin
      next_r.adpOv = 1'b1;
    end else if (r.adpOv && tmrDone[T_AOVCLR]) begin
      next_r.adpOv = 1'b0;
    end
    if (r.bypLatched) begin
      next_r.sysOv = 1'b0;
    end else if (!r.sysOv && tmrDone[T_SOVSET]) begin
      next_r.sysOv = 1'b1;
    end else if (r.sysOv && tmrDone[T_SOVCLR]) begin
      next_r.sysOv = 1'b0;
    end

    // Sequencer
    next_r.strapSrc = 1'b0;
    unique case (r.seq)
      SEQ_POR: begin
        // Wait one tick so the synchronisers hold real pin levels
        if (r.tick) begin
          next_r.seq = p[PIN_BIAS] ? SEQ_STRAP : SEQ_IDLE;
          // Source turns on with the state, so the pin settles for the whole phase
          next_r.strapSrc = p[PIN_BIAS];
          next_r.strapCnt = '0;
        end
      end
      SEQ_STRAP: begin
        next_r.strapSrc = 1'b1;
        if (r.tick) begin
          next_r.strapCnt = r.strapCnt + 1'b1;
        end
        if (r.strapCnt == STRAP_W'(STRAP_SETTLE_US)) begin
          next_r.strapDef = bbc_strap_decode(strapMv);
          next_r.strapSrc = 1'b0;
          next_r.seq      = SEQ_IDLE;
        end
      end
      SEQ_IDLE: begin
        if (rvsAllowed) begin
          next_r.seq      = SEQ_RVS;
          next_r.rvsArmed = 1'b0;
        end else if (fwdAllowed) begin
          next_r.seq   = SEQ_FWD;
          next_r.fwdSp = {1'b0, r.strapDef, 3'b000};
        end
      end
      SEQ_FWD: begin
        if (!fwdAllowed || rvsAllowed) begin
          next_r.seq = SEQ_IDLE;
        end
      end
      SEQ_RVS: begin
        if (p[PIN_RVS_SAFE]) begin
          next_r.rvsArmed = 1'b1;
        end
        if (!rvsAllowed) begin
          next_r.seq = SEQ_IDLE;
        end
      end
      SEQ_RETRY: begin
        if (tmrDone[T_RETRY]) begin
          next_r.wocShut = 1'b0;
          next_r.seq     = SEQ_IDLE;
        end
      end
      default: next_r.seq = SEQ_IDLE;
    endcase

    // Overcurrent: one count per window, shutdown at the trip limit
    if (!running || r.ctl2[C2_WOCDIS]) begin
      next_r.wocWin   = '0;
      next_r.wocUsed  = 1'b0;
      next_r.wocTrips = '0;
      next_r.wocSpan  = '0;
    end else begin
      if (r.wocUsed && r.tick) begin
        next_r.wocWin = r.wocWin + 1'b1;
        if (r.wocWin == 4'(WOC_WIN_US - 1)) begin
          next_r.wocWin  = '0;
          next_r.wocUsed = 1'b0;
        end
      end
      if (r.wocTrips != 3'h0 && r.tick) begin
        next_r.wocSpan = r.wocSpan + 1'b1;
        if (r.wocSpan == TMR_W'(WOC_SPAN_US - 1)) begin
          next_r.wocSpan  = '0;
          next_r.wocTrips = '0;
        end
      end
      if (p[PIN_WOC] && !r.wocUsed) begin
        next_r.wocUsed  = 1'b1;
        next_r.wocWin   = '0;
        next_r.wocTrips = r.wocTrips + 1'b1;
        if (r.wocTrips == 3'(WOC_TRIP_LIMIT - 1)) begin
          next_r.wocShut  = 1'b1;
          next_r.wocTrips = '0;
          next_r.wocSpan  = '0;
          next_r.seq      = SEQ_RETRY;
        end
      end
    end

    // Bypass latch holds until the control bit drops or the mode ends
    if (!r.ctl1[C1_BYPASS] || !running) begin
      next_r.bypLatched = 1'b0;
    end else if (p[PIN_BYP_WIN]) begin
      next_r.bypLatched = 1'b1;
    end

    // Outputs
    next_r.swEn = ((next_r.seq == SEQ_FWD && !next_r.sysOv) ||
                   (next_r.seq == SEQ_RVS && next_r.rvsArmed)) &&
                  !next_r.adpOv && !next_r.wocShut && !next_r.bypLatched;
    next_r.fwdPg = (next_r.seq == SEQ_FWD) && p[PIN_FWD_RNG] && !next_r.sysOv;
    next_r.reverse_power_good = (next_r.seq == SEQ_RVS) && next_r.rvsArmed && p[PIN_RVS_RNG];
    next_r.passOn  = next_r.bypLatched;
    next_r.refIn   = r.ctl1[C1_BYPASS] && !next_r.bypLatched;
    next_r.refCur  = running && !r.ctl1[C1_FASTREF];
    next_r.refFast = running && r.ctl1[C1_FASTREF];
    next_r.freq    = r.ctl1[C1_FREQ_HI:C1_FREQ_LO];
    next_r.deSel   = bbc_de_select(r.seq == SEQ_RVS, convMode);
    if (r.ctl1[C1_FORCE504]) begin
      next_r.dac = SP_5V040;
    end else begin
      next_r.dac = (r.seq == SEQ_RVS) ? r.rvsSp[SP_MSB:SP_LSB] : r.fwdSp[SP_MSB:SP_LSB];
    end

    // Minimum low-side on-time; the stretch also holds the next period off
    next_r.lsPrev = lowSideReq;
    if (lowSideReq && !r.lsPrev) begin
      next_r.lsCnt = LS_W'(MIN_LS_CYC);
    end else if (r.lsCnt != '0) begin
      next_r.lsCnt = r.lsCnt - 1'b1;
    end
    next_r.lsGate = lowSideReq || (deMode && (next_r.lsCnt != '0));
    next_r.hold   = deMode && !lowSideReq && (next_r.lsCnt != '0);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r          <= '0;
      r.seq      <= SEQ_POR;
      r.ctl1     <= CTL_RESET;
      r.ctl2     <= CTL_RESET;
      r.strapDef <= SP_5V004;
      r.fwdSp    <= {1'b0, SP_5V004, 3'b000};
      r.rvsSp    <= {1'b0, SP_5V004, 3'b000};
      r.dac      <= SP_5V004;
    end else begin
      r <= next_r;
    end
  end

  assign regRdData        = r.rdData;
  assign regRdValid       = r.rdValid;
  assign switchEnable     = r.swEn;
  assign forwardPowerGood = r.fwdPg;
  assign reversePowerGood = r.reverse_power_good;
  assign strapCurrentOn   = r.strapSrc;
  assign refCurrentOn     = r.refCur;
  assign refFastPath      = r.refFast;
  assign refToInput       = r.refIn;
  assign passSwitchesOn   = r.passOn;
  assign deCompSel        = r.deSel;
  assign freqSel          = r.freq;
  assign lowSideGate      = r.lsGate;
  assign periodHold       = r.hold;
  assign setpointCode     = r.dac;
  assign adapterOvFlag    = r.adpOv;
  assign systemOvFlag     = r.sysOv;
  assign wocShutdown      = r.wocShut;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_strap_start;
    $rose(r.seq == SEQ_STRAP);
  endsequence
  sequence s_strap_held;
    r.strapSrc [*8];
  endsequence

  a_strap_current: assert property (s_strap_start |-> s_strap_held)
    else $error("strap current not held while measuring");
  a_fwd_permit: assert property ($rose(r.seq == SEQ_FWD) |-> $past(fwdAllowed))
    else $error("forward entered without permission");
  a_fwd_reload: assert property ($rose(r.seq == SEQ_FWD) |-> r.fwdSp[SP_MSB:SP_LSB] == r.strapDef)
    else $error("forward setpoint not reloaded from strap");
  a_rvs_armed: assert property (r.swEn && r.seq == SEQ_RVS |-> r.rvsArmed)
    else $error("reverse switching before adapter safe");
  a_rvs_limit: assert property (r.rvsSp[SP_MSB:SP_LSB] <= SP_MAX)
    else $error("reverse setpoint above maximum");
  a_woc_stop: assert property ($rose(r.wocShut) |-> !r.swEn && r.seq == SEQ_RETRY)
    else $error("switching continued after overcurrent");
  a_sysov_good: assert property (r.sysOv |-> !r.fwdPg && !r.swEn)
    else $error("forward good held during overvoltage");
  a_aov_stop: assert property ($rose(r.adpOv) |-> !r.swEn ##1 !r.swEn)
    else $error("switching during adapter overvoltage");
  a_bypass_pass: assert property (r.bypLatched |-> r.passOn && !r.swEn)
    else $error("bypass latch without pass switches");
  a_ls_minimum: assert property (deMode && !lowSideReq ##1 lowSideReq [*2] ##1 !lowSideReq && deMode
                                 |-> r.lsGate [*5])
    else $error("low-side on-time below minimum");
  // Reset clears the edge detector, so a request already high on the release edge counts as a rise
  sequence s_ls_short_pulse;
    rst_n && $rose(lowSideReq) ##1 deMode [*7];
  endsequence
  a_ls_stretch: assert property (s_ls_short_pulse |=> r.lsGate)
    else $error("low-side gate dropped before minimum time");
  a_fast_ref: assert property (r.refFast |-> !r.refCur && $past(r.ctl1[C1_FASTREF]))
    else $error("fast reference path without its bit");
endmodule

// >>> shared/bbc_pkg.sv
// Shared constants, register map and types of the buck-boost mode and protection controller
package bbc_pkg;

  // ==========================================================
  // Clock and timebase
  localparam int CLK_NS     = 25;
  localparam int TICK_NS    = 1000;
  localparam int TICK_CYC   = TICK_NS / CLK_NS;
  localparam int TICK_W     = $clog2(TICK_CYC);
  localparam int TMR_W      = 21;

  // ==========================================================
  // Protection and sequencing times, in microseconds except the low-side minimum in ns
  localparam int ADP_OV_SET_US   = 10;
  localparam int ADP_OV_CLR_US   = 100;
  localparam int SYS_OV_SET_US   = 100;
  localparam int SYS_OV_CLR_US   = 100;
  localparam int WOC_WIN_US      = 10;
  localparam int WOC_TRIP_LIMIT  = 7;
  localparam int STRAP_SETTLE_US = 100;
  localparam int STRAP_W         = 7;
  localparam int MIN_LS_NS       = 200;
  localparam int MIN_LS_CYC      = (MIN_LS_NS + CLK_NS - 1) / CLK_NS;
  localparam int LS_W            = 8;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_FWD_SP = 8'h15;
  localparam logic [7:0] ADDR_RVS_SP = 8'h49;
  localparam logic [7:0] ADDR_CTL1   = 8'h3C;
  localparam logic [7:0] ADDR_CTL2   = 8'h3D;
  localparam logic [7:0] ADDR_STATUS = 8'h3E;

  // First control register fields
  localparam int C1_FORCE504 = 0;
  localparam int C1_FASTREF  = 3;
  localparam int C1_BYPASS   = 4;
  localparam int C1_FREQ_LO  = 7;
  localparam int C1_FREQ_HI  = 9;
  localparam int C1_RVS      = 11;
  localparam int C1_SKIPAZ   = 12;
  localparam int C1_SKIPTRIM = 13;
  // Second control register fields
  localparam int C2_WOCDIS   = 1;
  localparam int C2_FWDFAST  = 3;
  localparam int C2_RVSFAST  = 4;
  localparam int C2_FWDEN    = 6;
  localparam int C2_WOCLONG  = 12;
  localparam int C2_RVSLONG  = 13;

  // Setpoint field sits in bits 14..3, 12 mV per code
  localparam int SP_LSB = 3;
  localparam int SP_MSB = 14;
  localparam logic [11:0] SP_5V004  = 12'h1A1;
  localparam logic [11:0] SP_9V000  = 12'h2EE;
  localparam logic [11:0] SP_12V000 = 12'h3E8;
  localparam logic [11:0] SP_16V008 = 12'h536;
  localparam logic [11:0] SP_20V004 = 12'h683;
  localparam logic [11:0] SP_5V040  = 12'h1A4;
  localparam logic [11:0] SP_MAX    = 12'h683;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // Strap voltage boundaries in mV, strap current times resistance
  localparam logic [11:0] STRAP_T1 = 12'h140;
  localparam logic [11:0] STRAP_T2 = 12'h302;
  localparam logic [11:0] STRAP_T3 = 12'h578;
  localparam logic [11:0] STRAP_T4 = 12'h8D4;

  // Host scales current commands by this when sense resistors differ
  localparam int CUR_MA_PER_LSB = 4;

  // ==========================================================
  // Synchronised pin indices
  localparam int PIN_FWD_EN  = 0;
  localparam int PIN_RVS_EN  = 1;
  localparam int PIN_BIAS    = 2;
  localparam int PIN_ADP_OK  = 3;
  localparam int PIN_SYS_OK  = 4;
  localparam int PIN_AOV_HI  = 5;
  localparam int PIN_AOV_LO  = 6;
  localparam int PIN_SOV_HI  = 7;
  localparam int PIN_SOV_LO  = 8;
  localparam int PIN_FWD_RNG = 9;
  localparam int PIN_RVS_RNG = 10;
  localparam int PIN_RVS_SAFE = 11;
  localparam int PIN_BYP_WIN = 12;
  localparam int PIN_WOC     = 13;
  localparam int N_PIN       = 14;

  // Timer slots
  localparam int T_RVSPIN = 0;
  localparam int T_AOVSET = 1;
  localparam int T_AOVCLR = 2;
  localparam int T_SOVSET = 3;
  localparam int T_SOVCLR = 4;
  localparam int T_RETRY  = 5;
  localparam int N_TMR    = 6;

  typedef enum logic [2:0] {
    SEQ_POR   = 3'b000,
    SEQ_STRAP = 3'b001,
    SEQ_IDLE  = 3'b010,
    SEQ_FWD   = 3'b011,
    SEQ_RVS   = 3'b100,
    SEQ_RETRY = 3'b101
  } bbc_seq_t;

  typedef enum logic [1:0] {
    CONV_BUCK  = 2'b00,
    CONV_BOOST = 2'b01,
    CONV_BB    = 2'b10
  } bbc_conv_t;

  typedef enum logic [1:0] {
    DE_PH1_GND  = 2'b00,
    DE_PH1_VOUT = 2'b01,
    DE_PH2_GND  = 2'b10,
    DE_PH1_ADP  = 2'b11
  } bbc_de_t;

  function automatic logic [11:0] bbc_strap_decode(input logic [11:0] mv);
    if (mv < STRAP_T1) return SP_5V004;
    else if (mv < STRAP_T2) return SP_9V000;
    else if (mv < STRAP_T3) return SP_12V000;
    else if (mv < STRAP_T4) return SP_16V008;
    else return SP_20V004;
  endfunction

  function automatic bbc_de_t bbc_de_select(input logic rvs, input bbc_conv_t m);
    if (m == CONV_BUCK) return rvs ? DE_PH2_GND : DE_PH1_GND;
    else return rvs ? DE_PH1_ADP : DE_PH1_VOUT;
  endfunction

endpackage

// >>> shared/bbc_tmr_if.sv
// Handshake between the controller and one debounce timer
`timescale 1ns/1ps
interface bbc_tmr_if
  import bbc_pkg::*;
  ();
  logic             tick;
  logic             cond;
  logic [TMR_W-1:0] limit;
  logic             done;
  modport tmr  (input tick, input cond, input limit, output done);
  modport user (output tick, output cond, output limit, input done);
endinterface

// >>> rtl/bbc_debounce.sv
// Debounce timer counting timebase ticks while its condition holds
`timescale 1ns/1ps
module bbc_debounce
  import bbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  bbc_tmr_if.tmr   t
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             done;
  } bbc_deb_t;

  bbc_deb_t s;
  bbc_deb_t next_s;

  always_comb begin
    next_s = s;
    // Dropping the condition clears the count, so glitches never add up
    if (!t.cond) begin
      next_s = '0;
    end else begin
      if (t.tick && (s.cnt < t.limit)) begin
        next_s.cnt = s.cnt + 1'b1;
      end
      next_s.done = (next_s.cnt >= t.limit);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign t.done = s.done;
endmodule

// >>> bench/bbc_bridge_model.sv
// Far-side model: output rail and overcurrent comparator of the bridge
`timescale 1ns/1ps
module bbc_bridge_model (
  input  wire logic clk,
  input  wire logic switchEnable,
  input  wire logic fault,
  output logic      fwdInRange,
  output logic      wocTrip
);
  int ramp = 0;
  int gap  = 0;
  initial begin
    fwdInRange = 0;
    wocTrip = 0;
  end
  // The rail takes time to charge, so power-good cannot follow switching at once
  always @(posedge clk) begin
    ramp <= switchEnable ? ramp + 1 : 0;
    fwdInRange <= ramp > 100;
    gap <= fault && gap < 479 ? gap + 1 : 0;
    // A short trips the comparator once every 12 us while it lasts
    wocTrip <= fault && gap < 4;
  end
endmodule

// >>> bench/bbc_top_tb.sv
// Self-checking bench of the buck-boost mode and protection controller
`timescale 1ns/1ps
module bbc_top_tb import bbc_pkg::*; ;
  int seed = 88552, miscompares = 0, cmp_count = 0, cycles = 0, k, j;
  logic clk = 0, rst_n = 0, regWr = 0, regRd = 0, fault = 0, forwardEnablePin = 1, reverseEnablePin = 0;
  logic biasFromAdapter = 1, adapterAbove4v1 = 1, systemAbove4v1 = 0, rvsInRange = 0, adapterBelowRvsOv = 1;
  logic bypassWindow = 0, deMode = 1, lowSideReq = 0;
  logic [7:0] regAddr = 0;
  logic [15:0] regWrData = 0, d, v, regRdData;
  logic [11:0] strapMv = 0, setpointCode;
  logic [1:0] ovHi = 0, ovLo = 3;
  logic [2:0] freqSel;
  bbc_conv_t convMode = CONV_BUCK;
  bbc_de_t deCompSel;
  logic regRdValid, switchEnable, forwardPowerGood, reversePowerGood, strapCurrentOn, refCurrentOn, refFastPath;
  logic refToInput, passSwitchesOn, lowSideGate, periodHold, adapterOvFlag, systemOvFlag, wocShutdown;
  logic fwdInRange, wocTrip;
  wire adapterOvHigh = ovHi[0], systemOvHigh = ovHi[1], adapterOvLow = ovLo[0], systemOvLow = ovLo[1];
  wire [1:0] ovFlag = {systemOvFlag, adapterOvFlag};
  bbc_top #(.LONG_US(20), .SHORT_US(8), .WOC_SPAN_US(100)) dut (.*);
  bbc_bridge_model partner (.clk, .switchEnable, .fault, .fwdInRange, .wocTrip);
  always #12.5 clk = ~clk;
  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    lowSideReq <= 1'($random(seed));
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    regWr <= 1;
    regAddr <= a;
    regWrData <= w;
    cyc(1);
    regWr <= 0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] r);
    regRd <= 1;
    regAddr <= a;
    cyc(1);
    regRd <= 0;
    r = 16'hXXXX;
    repeat (2) begin
      #1;
      if (regRdValid === 1'b1) r = regRdData;
      cyc(1);
    end
  endtask
  task automatic rst();
    rst_n <= 0;
    cyc(16);
    rst_n <= 1;
    cyc(1);
  endtask
  function automatic logic [11:0] strapExp(input logic [11:0] mv);
    return mv < STRAP_T1 ? SP_5V004 : mv < STRAP_T2 ? SP_9V000 : mv < STRAP_T3 ? SP_12V000 :
           mv < STRAP_T4 ? SP_16V008 : SP_20V004;
  endfunction
  // ==========================================================
  // Scenarios
  initial begin
    cyc(1);
    for (k = 0; k < 4; k++) begin
      strapMv <= k == 0 ? 12'($random(seed)) % 12'hC00 : k == 1 ? STRAP_T1 - 12'h001 : k == 2 ? STRAP_T1 : STRAP_T4;
      convMode <= bbc_conv_t'(k % 3);
      rst();
      chk("setpoint", 16'(setpointCode), 16'h01A1);
      cyc(100);
      chk("strap on", 16'(strapCurrentOn), 16'h0001);
      cyc(4400);
      chk("strap", 16'(setpointCode), 16'(strapExp(strapMv)));
      chk("switch", 16'({switchEnable, forwardPowerGood}), 16'h0003);
      chk("de sel", 16'(deCompSel), 16'(k % 3 ? DE_PH1_VOUT : DE_PH1_GND));
      wr(ADDR_FWD_SP, 16'h1000);
      forwardEnablePin <= 0;
      cyc(10);
      chk("switch off", 16'(switchEnable), 16'h0000);
      forwardEnablePin <= 1;
      cyc(10);
      chk("reload", 16'(setpointCode), 16'(strapExp(strapMv)));
    end
    rd(ADDR_RVS_SP, d);
    chk("rvs default", d, 16'h0D08);
    wr(ADDR_RVS_SP, 16'h7FF8);
    rd(ADDR_RVS_SP, d);
    chk("rvs clamp", d, {1'b0, SP_MAX, 3'h0});
    rd(8'h00, d);
    chk("unmapped", d, 16'h0000);
    for (k = 0; k < 4; k++) begin
      v = 16'($random(seed)) & 16'h0388;
      wr(ADDR_CTL1, v);
      cyc(3);
      chk("freq", 16'(freqSel), 16'(v[9:7]));
      chk("ref path", 16'({refFastPath, refCurrentOn}), v[3] ? 16'h0002 : 16'h0001);
    end
    wr(ADDR_CTL1, 16'h0010);
    cyc(3);
    chk("bypass ramp", 16'({refToInput, passSwitchesOn}), 16'h0002);
    bypassWindow <= 1;
    cyc(5);
    chk("bypass", 16'({refToInput, passSwitchesOn, switchEnable}), 16'h0002);
    bypassWindow <= 0;
    wr(ADDR_CTL1, 16'h0000);
    for (j = 0; j < 2; j++) begin
      k = j ? SYS_OV_SET_US : ADP_OV_SET_US;
      ovHi[j] <= 1;
      ovLo[j] <= 0;
      cyc(40 * k - 80);
      ovHi[j] <= 0;
      cyc(2);
      chk("ov short", 16'(ovFlag[j]), 16'h0000);
      ovHi[j] <= 1;
      cyc(40 * k + 160);
      chk("ov set", 16'({ovFlag[j], switchEnable, forwardPowerGood}), 16'h0004);
      ovHi[j] <= 0;
      ovLo[j] <= 1;
      cyc(40 * (j ? SYS_OV_CLR_US : ADP_OV_CLR_US) - 120);
      chk("ov hold", 16'(ovFlag[j]), 16'h0001);
      cyc(400);
      chk("ov clear", 16'({ovFlag[j], switchEnable}), 16'h0001);
      cyc(200);
    end
    fault <= 1;
    cyc(6 * 480 - 40);
    chk("woc six", 16'(wocShutdown), 16'h0000);
    cyc(80);
    chk("woc seven", 16'({wocShutdown, switchEnable}), 16'h0002);
    fault <= 0;
    cyc(200);
    chk("woc wait", 16'({wocShutdown, switchEnable}), 16'h0002);
    cyc(4600);
    chk("woc retry", 16'({wocShutdown, switchEnable}), 16'h0001);
    // Software swap into reverse with the adapter side still high, then back
    systemAbove4v1 <= 1;
    adapterBelowRvsOv <= 0;
    rvsInRange <= 1;
    wr(ADDR_CTL1, 16'h3000);
    wr(ADDR_CTL1, 16'h3009);
    wr(ADDR_CTL1, 16'h3809);
    cyc(10);
    chk("rvs wait", 16'({switchEnable, reversePowerGood}), 16'h0000);
    adapterBelowRvsOv <= 1;
    cyc(10);
    chk("reverse", 16'({switchEnable, reversePowerGood, forwardPowerGood}), 16'h0006);
    chk("force", 16'(setpointCode), 16'h01A4);
    wr(ADDR_CTL1, 16'h3009);
    cyc(10);
    chk("back", 16'({switchEnable, reversePowerGood}), 16'h0002);
    reverseEnablePin <= 1;
    cyc(250);
    chk("pin wait", 16'(reversePowerGood), 16'h0000);
    cyc(200);
    chk("pin rvs", 16'(reversePowerGood), 16'h0001);
    report_and_stop();
  end
endmodule
